//--- rtl/stlg_timing.sv
// Purpose: line timing for a linear sensor and its lamps, APB programmed
// Assumes: pclk is the master clock; one pixel is eight clocks
// Notes: one wait state on every APB access; outputs are registered
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - mode 0 lamps low, reset default
// R2 - mode 1 red, blue from points
// R3 - mode 1 green is PWM stream
// R4 - PWM counter wraps every 4096 clocks
// R5 - mode 2 lamps follow line colour
// R6 - lamp rises at its on point
// R7 - lamp falls at its off point
// R8 - mode 3 all lamps every line
// R9 - counters run unless in standby
// R10 - scan starts at line start, red in mode 2
// R11 - input polarity is configurable
// R12 - sample points independent, kept two apart; the code does not enforce any spacing
// R13 - no double sampling uses internal reference
// R14 - two extra programmable pixel pulses
// R15 - pixel pulses cleared at line end
// R16 - clamp cleared at black region end
// R17 - both transfer pulses same width
// R18 - zero guard: transfer and shift clock together
// R19 - CIS mode 1 pulse at shift rise
// R20 - CIS mode 2 pulse centred on shift
// R21 - three channel: RGB per line, coefficients
// R22 - three channel transfer position 1 or 2
// R23 - colour counter R, G, B at line start
module stlg_timing #(
    parameter int PW = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // lamps
    output logic lamp_r,
    output logic lamp_g,
    output logic lamp_b,
    // sensor clocks
    output logic transfer_gate_pulse_a,
    output logic transfer_gate_pulse_b,
    output logic shift_clk,
    output logic reset_gate_pulse,
    output logic extra_pixel_pulse_a,
    output logic extra_pixel_pulse_b,
    // analog front end
    output logic clamp,
    output logic sample_ref,
    output logic sample_sig,
    output logic ref_internal,
    output logic input_invert,
    output logic [1:0] adc_chan,
    output logic [1:0] coef_color,
    // state
    output logic scanning
);
    logic [31:0] ctrl_reg;
    logic [PW-1:0] line_end_reg, ob_end_reg, pix_reg;
    logic [11:0] pwm_reg;
    logic [15:0] tr_reg;
    logic [23:0] pulse_reg;
    logic [7:0] sample_reg;
    logic [PW-1:0] lamp_pt_reg [0:5];
    logic [2:0] phase_reg;
    logic [3:0] tr_dly_reg;
    logic pending_reg;
    stlg_pkg::stlg_color_t color_reg;
    logic [1:0] mode, cis, cidx;
    logic run, pix_end, line_last, line_start, acc, wr, setup;
    logic pwm_out, tr_base, tr_sel, phi_hold;
    logic [2:0] lit;
    logic [PW+2:0] clk_pos, tr_end, hdr_end;
    logic [31:0] rdata;

    initial begin
        if (PW < 8 || PW > 16) $error("stlg_timing pixel width out of range");
    end

    function automatic logic in_win(input logic [2:0] ph, input logic [2:0] s,
                                    input logic [2:0] e);
        in_win = (ph >= s) && (ph < e);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= stlg_pkg::OFF_STATUS);
    endfunction

    // apb: first access cycle loads read data, second completes
    assign setup = psel && penable && !pready;
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite && mapped(paddr) && !pslverr;
    assign mode = ctrl_reg[stlg_pkg::CTRL_MODE_LO +: 2];
    assign cis = ctrl_reg[stlg_pkg::CTRL_CIS_LO +: 2];
    assign run = !ctrl_reg[stlg_pkg::CTRL_STANDBY];
    assign cidx = stlg_pkg::col_idx(color_reg);

    always_comb begin
        rdata = 32'h0;
        unique case (paddr)
            stlg_pkg::OFF_CTRL: rdata = ctrl_reg;
            stlg_pkg::OFF_LINE_END: rdata = 32'(line_end_reg);
            stlg_pkg::OFF_OB_END: rdata = 32'(ob_end_reg);
            stlg_pkg::OFF_PWM: rdata = 32'(pwm_reg);
            stlg_pkg::OFF_TR: rdata = 32'(tr_reg);
            stlg_pkg::OFF_PULSE: rdata = 32'(pulse_reg);
            stlg_pkg::OFF_SAMPLE: rdata = 32'(sample_reg);
            stlg_pkg::OFF_STATUS: rdata = {12'h0, pending_reg, scanning, cidx, 16'(pix_reg)};
            default: begin
                if (mapped(paddr) && paddr >= stlg_pkg::OFF_LAMP_BASE)
                    rdata = 32'(lamp_pt_reg[3'((paddr - stlg_pkg::OFF_LAMP_BASE) >> 2)]);
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped(paddr);
            if (setup) prdata <= rdata;
        end
    end

    // configuration writes; the status word is read only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= stlg_pkg::CTRL_RST; // R1
            line_end_reg <= PW'(stlg_pkg::LINE_END_RST);
            ob_end_reg <= PW'(stlg_pkg::OB_END_RST);
            pwm_reg <= stlg_pkg::PWM_RST;
            tr_reg <= stlg_pkg::TR_RST;
            pulse_reg <= stlg_pkg::PULSE_RST;
            sample_reg <= stlg_pkg::SAMPLE_RST;
            for (int i = 0; i < 6; i++) lamp_pt_reg[i] <= PW'(stlg_pkg::LAMP_RST);
        end else if (wr) begin
            unique case (paddr)
                stlg_pkg::OFF_CTRL: ctrl_reg <= pwdata & 32'h0007_3edf;
                stlg_pkg::OFF_LINE_END: line_end_reg <= pwdata[PW-1:0];
                stlg_pkg::OFF_OB_END: ob_end_reg <= pwdata[PW-1:0];
                stlg_pkg::OFF_PWM: pwm_reg <= pwdata[11:0]; // R3
                stlg_pkg::OFF_TR: tr_reg <= pwdata[15:0]; // R17
                stlg_pkg::OFF_PULSE: pulse_reg <= pwdata[23:0];
                stlg_pkg::OFF_SAMPLE: sample_reg <= pwdata[7:0]; // R12
                stlg_pkg::OFF_STATUS: ;
                default: lamp_pt_reg[3'((paddr - stlg_pkg::OFF_LAMP_BASE) >> 2)] <= pwdata[PW-1:0];
            endcase
        end
    end

    // free-running pixel position; standby is the only thing that stops it
    assign pix_end = run && (phase_reg == stlg_pkg::PHASE_LAST);
    assign line_last = (pix_reg == line_end_reg);
    assign line_start = pix_end && line_last;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 3'h0;
            pix_reg <= '0;
        end else if (run) begin
            phase_reg <= phase_reg + 3'h1; // R9
            if (pix_end) pix_reg <= line_last ? '0 : pix_reg + 1'b1; // R9
        end
    end

    // line colour, in step with the transfer pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) color_reg <= stlg_pkg::COL_R;
        else if (line_start) begin
            unique case (color_reg)
                stlg_pkg::COL_R: color_reg <= stlg_pkg::COL_G; // R23
                stlg_pkg::COL_G: color_reg <= stlg_pkg::COL_B; // R23
                stlg_pkg::COL_B: color_reg <= stlg_pkg::COL_R; // R23
                default: color_reg <= stlg_pkg::COL_R;
            endcase
        end
    end

    // a request waits for a line boundary; a new request wins over clearing the pending flag, and the start wins over a stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_reg <= 1'b0;
            scanning <= 1'b0;
        end else begin
            if (wr && paddr == stlg_pkg::OFF_CTRL && pwdata[stlg_pkg::CTRL_SCAN_REQ])
                pending_reg <= 1'b1;
            else if (pending_reg && line_start &&
                     (mode != stlg_pkg::ILLUM_SEQ || color_reg == stlg_pkg::COL_B))
                pending_reg <= 1'b0; // R10
            if (pending_reg && line_start &&
                (mode != stlg_pkg::ILLUM_SEQ || color_reg == stlg_pkg::COL_B))
                scanning <= 1'b1; // R10
            else if (wr && paddr == stlg_pkg::OFF_CTRL && pwdata[stlg_pkg::CTRL_STOP])
                scanning <= 1'b0;
        end
    end

    // lamp points and brightness stream
    stlg_pwm #(.W(stlg_pkg::PWM_W)) u_pwm (
        .clk(pclk),
        .rst_n(presetn),
        .duty(pwm_reg),
        .pwm_out(pwm_out)
    );

    for (genvar g = 0; g < 3; g++) begin : g_lamp
        stlg_lamp_cmp #(.PW(PW)) u_cmp (
            .clk(pclk),
            .rst_n(presetn),
            .tick(run && phase_reg == 3'h0),
            .pix(pix_reg),
            .on_pt(lamp_pt_reg[2*g]),
            .off_pt(lamp_pt_reg[2*g+1]),
            .lit(lit[g])
        );
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_r <= 1'b0;
            lamp_g <= 1'b0;
            lamp_b <= 1'b0;
        end else begin
            unique case (mode)
                stlg_pkg::ILLUM_OFF: {lamp_b, lamp_g, lamp_r} <= 3'h0; // R1
                stlg_pkg::ILLUM_WHITE: {lamp_b, lamp_g, lamp_r} <= {lit[2], pwm_out, lit[0]}; // R2 R3
                stlg_pkg::ILLUM_SEQ: {lamp_b, lamp_g, lamp_r} <= lit & color_reg; // R5
                stlg_pkg::ILLUM_ALL: {lamp_b, lamp_g, lamp_r} <= lit; // R8
            endcase
            if (!run) {lamp_b, lamp_g, lamp_r} <= 3'h0;
        end
    end

    // transfer pulse: width ends mid-pixel so a zero guard lines up with the shift clock
    assign clk_pos = {pix_reg, phase_reg};
    assign tr_end = (PW+3)'({tr_reg[7:0], 3'h0}) - (PW+3)'(stlg_pkg::PHASE_HALF);
    assign hdr_end = tr_end + (PW+3)'({tr_reg[15:8], 3'h0});

    always_comb begin
        tr_base = 1'b0;
        phi_hold = 1'b0;
        unique case (cis)
            stlg_pkg::CIS_EDGE: tr_base = (pix_reg == '0); // R19
            stlg_pkg::CIS_CENTRE:
                tr_base = (line_last && phase_reg >= stlg_pkg::PHASE_CENTRE) ||
                          (pix_reg == '0 && phase_reg < stlg_pkg::PHASE_CENTRE); // R20
            default: begin
                tr_base = (tr_reg[7:0] != 8'h0) && (clk_pos < tr_end); // R17
                phi_hold = (tr_reg[7:0] != 8'h0) && (clk_pos < hdr_end); // R18
            end
        endcase
    end

    // position 2 delays the pulse half a pixel, into the shift clock low time
    assign tr_sel = (ctrl_reg[stlg_pkg::CTRL_TRIPLE] && ctrl_reg[stlg_pkg::CTRL_POS_LO + cidx])
                    ? tr_dly_reg[3] : tr_base; // R22

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tr_dly_reg <= 4'h0;
            transfer_gate_pulse_a <= 1'b0;
            transfer_gate_pulse_b <= 1'b0;
            shift_clk <= 1'b0;
        end else begin
            tr_dly_reg <= {tr_dly_reg[2:0], tr_base};
            transfer_gate_pulse_a <= run && tr_sel; // R17
            transfer_gate_pulse_b <= run && tr_sel && ctrl_reg[stlg_pkg::CTRL_TRB_EN]; // R17
            shift_clk <= run && (phi_hold || phase_reg < stlg_pkg::PHASE_HALF); // R18
        end
    end

    // pixel-rate pulses, clamp and sample strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_gate_pulse <= 1'b0;
            extra_pixel_pulse_a <= 1'b0;
            extra_pixel_pulse_b <= 1'b0;
            clamp <= 1'b0;
            sample_ref <= 1'b0;
            sample_sig <= 1'b0;
        end else begin
            reset_gate_pulse <= run && !line_last && in_win(phase_reg,
                pulse_reg[stlg_pkg::PUL_RS_LO +: 3], pulse_reg[stlg_pkg::PUL_RS_HI +: 3]); // R15
            extra_pixel_pulse_a <= run && !line_last && in_win(phase_reg,
                pulse_reg[stlg_pkg::PUL_XA_LO +: 3], pulse_reg[stlg_pkg::PUL_XA_HI +: 3]); // R14 R15
            extra_pixel_pulse_b <= run && !line_last && in_win(phase_reg,
                pulse_reg[stlg_pkg::PUL_XB_LO +: 3], pulse_reg[stlg_pkg::PUL_XB_HI +: 3]); // R14 R15
            if (line_start) clamp <= 1'b1;
            else if (pix_reg == ob_end_reg) clamp <= 1'b0; // R16
            sample_ref <= run && ctrl_reg[stlg_pkg::CTRL_CDS] &&
                          phase_reg == sample_reg[stlg_pkg::SMP_REF +: 3]; // R12 R13
            sample_sig <= run && phase_reg == sample_reg[stlg_pkg::SMP_SIG +: 3]; // R12 R13
        end
    end

    // front end steering; in three channel mode the colour picks channel and coefficients
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_internal <= 1'b0;
            input_invert <= 1'b0;
            adc_chan <= 2'h0;
            coef_color <= 2'h0;
        end else begin
            ref_internal <= !ctrl_reg[stlg_pkg::CTRL_CDS]; // R13
            input_invert <= ctrl_reg[stlg_pkg::CTRL_INVERT]; // R11
            adc_chan <= ctrl_reg[stlg_pkg::CTRL_TRIPLE] ? cidx :
                        ctrl_reg[stlg_pkg::CTRL_CHAN_LO +: 2]; // R21
            coef_color <= ctrl_reg[stlg_pkg::CTRL_TRIPLE] ? cidx :
                          ctrl_reg[stlg_pkg::CTRL_CHAN_LO +: 2]; // R21
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_mode0_lamps_low: assert property ((mode == stlg_pkg::ILLUM_OFF) ##1
        (mode == stlg_pkg::ILLUM_OFF) |-> !lamp_r && !lamp_g && !lamp_b) // R1
        else $error("lamp lit in mode 0");
    chk_lamp_r_on: assert property ((mode == stlg_pkg::ILLUM_ALL && run && phase_reg == 3'h0 &&
        pix_reg == lamp_pt_reg[0] && pix_reg != lamp_pt_reg[1]) ##1 $stable(ctrl_reg)
        |=> lamp_r) else $error("red lamp missed its on point"); // R6
    chk_lamp_r_off: assert property ((mode == stlg_pkg::ILLUM_ALL && run && phase_reg == 3'h0 &&
        pix_reg == lamp_pt_reg[1]) ##1 $stable(ctrl_reg)
        |=> !lamp_r) else $error("red lamp missed its off point"); // R7
    chk_seq_one_lamp: assert property ($past(mode) == stlg_pkg::ILLUM_SEQ &&
        mode == stlg_pkg::ILLUM_SEQ |-> $onehot0({lamp_b, lamp_g, lamp_r})) // R5
        else $error("more than one lamp in mode 2");
    chk_colour_step: assert property (line_start && color_reg == stlg_pkg::COL_B
        |=> color_reg == stlg_pkg::COL_R) else $error("colour did not wrap to red"); // R23
    chk_scan_on_red: assert property ($rose(scanning) && mode == stlg_pkg::ILLUM_SEQ
        |-> color_reg == stlg_pkg::COL_R && pix_reg == '0 && phase_reg == 3'h0) // R10
        else $error("scan began off a red line start");
    chk_pulses_line_end: assert property (run && line_last |=> // R15
        !reset_gate_pulse && !extra_pixel_pulse_a && !extra_pixel_pulse_b)
        else $error("pixel pulse high at line end");
    chk_clamp_ob_end: assert property (pix_reg == ob_end_reg && !line_start
        |=> !clamp) else $error("clamp held past black region"); // R16
    chk_tr_same_width: assert property (ctrl_reg[stlg_pkg::CTRL_TRB_EN] ##1
        ctrl_reg[stlg_pkg::CTRL_TRB_EN] |-> transfer_gate_pulse_a == transfer_gate_pulse_b) // R17
        else $error("transfer pulses differ");
    chk_cis_edge_len: assert property (cis == stlg_pkg::CIS_EDGE && run &&
        !ctrl_reg[stlg_pkg::CTRL_TRIPLE] && $rose(transfer_gate_pulse_a)
        |-> transfer_gate_pulse_a [*8] ##1 !transfer_gate_pulse_a) // R19
        else $error("cis mode 1 pulse not one shift period");
endmodule
`default_nettype wire

//--- rtl/stlg_pkg.sv
// Purpose: shared constants for the sensor and lamp timing generator
// Assumes: APB slave, 32-bit data, byte addresses, one word per register
// Notes: pixel period is eight master clocks
package stlg_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LINE_END = 8'h04;
    localparam logic [7:0] OFF_OB_END = 8'h08;
    localparam logic [7:0] OFF_PWM = 8'h0c;
    localparam logic [7:0] OFF_TR = 8'h10;
    localparam logic [7:0] OFF_PULSE = 8'h14;
    localparam logic [7:0] OFF_SAMPLE = 8'h18;
    localparam logic [7:0] OFF_LAMP_BASE = 8'h1c;
    localparam logic [7:0] OFF_LAMP_LAST = 8'h30;
    localparam logic [7:0] OFF_STATUS = 8'h34;
    // control fields
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_TRIPLE = 2;
    localparam int CTRL_CDS = 3;
    localparam int CTRL_INVERT = 4;
    localparam int CTRL_SCAN_REQ = 5;
    localparam int CTRL_CIS_LO = 6;
    localparam int CTRL_STOP = 8;
    localparam int CTRL_STANDBY = 9;
    localparam int CTRL_TRB_EN = 10;
    localparam int CTRL_CHAN_LO = 12;
    localparam int CTRL_POS_LO = 16;
    // pulse and sample phase fields, three bits each; transfer guard field, eight bits
    localparam int PUL_RS_LO = 0;
    localparam int PUL_RS_HI = 4;
    localparam int PUL_XA_LO = 8;
    localparam int PUL_XA_HI = 12;
    localparam int PUL_XB_LO = 16;
    localparam int PUL_XB_HI = 20;
    localparam int SMP_REF = 0;
    localparam int SMP_SIG = 4;
    localparam int TR_GUARD_LO = 8;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0008;
    localparam logic [15:0] LINE_END_RST = 16'h00ff;
    localparam logic [15:0] OB_END_RST = 16'h0010;
    localparam logic [11:0] PWM_RST = 12'h800;
    localparam logic [15:0] TR_RST = 16'h0202;
    localparam logic [23:0] PULSE_RST = 24'h200_200 | 24'h010_010;
    localparam logic [7:0] SAMPLE_RST = 8'h51;
    localparam logic [15:0] LAMP_RST = 16'hffff;
    // timing
    localparam int MCLK_HZ = 20_000_000;
    localparam int ADC_DIV = 8;
    localparam logic [2:0] PHASE_LAST = 3'(ADC_DIV - 1);
    localparam logic [2:0] PHASE_HALF = 3'(ADC_DIV / 2);
    localparam logic [2:0] PHASE_CENTRE = 3'h6;
    localparam int PWM_W = 12;
    // illumination and sensor transfer modes
    localparam logic [1:0] ILLUM_OFF = 2'h0;
    localparam logic [1:0] ILLUM_WHITE = 2'h1;
    localparam logic [1:0] ILLUM_SEQ = 2'h2;
    localparam logic [1:0] ILLUM_ALL = 2'h3;
    localparam logic [1:0] CIS_NORMAL = 2'h0;
    localparam logic [1:0] CIS_EDGE = 2'h1;
    localparam logic [1:0] CIS_CENTRE = 2'h2;
    typedef enum logic [2:0] {
        COL_R = 3'b001,
        COL_G = 3'b010,
        COL_B = 3'b100
    } stlg_color_t;

    function automatic logic [1:0] col_idx(input stlg_color_t c);
        unique case (c)
            COL_R: col_idx = 2'h0;
            COL_G: col_idx = 2'h1;
            COL_B: col_idx = 2'h2;
            default: col_idx = 2'h0;
        endcase
    endfunction
endpackage

//--- rtl/stlg_pwm.sv
// Purpose: lamp brightness pulse stream
// Assumes: counter runs on every master clock
// Notes: duty is setting over two to the width
`timescale 1ns/1ps
`default_nettype none
module stlg_pwm #(
    parameter int W = stlg_pkg::PWM_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // duty setting and stream
    input wire logic [W-1:0] duty,
    output logic pwm_out
);
    logic [W-1:0] cnt_reg;

    initial begin
        if (W < 2 || W > 16) $error("stlg_pwm width out of range");
    end

    // natural wrap gives a period of two to the width
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_reg <= '0; // R4
        else cnt_reg <= cnt_reg + 1'b1; // R4
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pwm_out <= 1'b0;
        else pwm_out <= (cnt_reg < duty); // R3
    end

    chk_pwm_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        (cnt_reg == '1) |=> (cnt_reg == '0)) else $error("pwm counter did not wrap"); // R4
endmodule
`default_nettype wire

//--- rtl/stlg_lamp_cmp.sv
// Purpose: one lamp on/off point comparator
// Assumes: pixel counter never passes line end
// Notes: off wins when both points match
`timescale 1ns/1ps
`default_nettype none
module stlg_lamp_cmp #(
    parameter int PW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pixel position
    input wire logic tick,
    input wire logic [PW-1:0] pix,
    // programmed points
    input wire logic [PW-1:0] on_pt,
    input wire logic [PW-1:0] off_pt,
    // lamp state
    output logic lit
);
    // points beyond line end are never met, so the lamp stays as it is
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) lit <= 1'b0;
        else if (tick && pix == off_pt) lit <= 1'b0; // R7
        else if (tick && pix == on_pt) lit <= 1'b1; // R6
    end
endmodule
`default_nettype wire

//--- sim/stlg_sensor_model.sv
// Purpose: stand-in for the sensor and lamp drivers at the far side
// Assumes: every watched line is a registered level of the timing block
// Notes: a driver sees only levels, so high-clock totals are what it can judge
`timescale 1ns/1ps
`default_nettype none
module stlg_sensor_model (
    // clock and control
    input wire logic clk,
    input wire logic clr,
    // watched lines
    input wire logic [7:0] sig,
    // high-clock totals
    output logic [15:0] cnt [8]
);
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            cnt[i] <= clr ? 16'h0000 : cnt[i] + 16'(sig[i]);
        end
    end
endmodule
`default_nettype wire

//--- sim/sensor_lamp_timing_gen_tb.sv
// Purpose: self-checking bench for the sensor and lamp timing generator
// Assumes: line end 15, so a line is 128 clocks
// Notes: windows span whole lines so the count does not depend on phase
`timescale 1ns/1ps
`default_nettype none
module sensor_lamp_timing_gen_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv, s;
    logic lamp_r, lamp_g, lamp_b, tra, trb, clamp, sref, ssig, ref_int, inv, scan;
    logic [1:0] chan, coef;
    logic [15:0] cnt [8];
    logic [31:0] pts [6] = '{32'h2, 32'h5, 32'h1, 32'h20, 32'h20, 32'h3};
    int num_errors, n_compared;
    always #25 pclk = ~pclk;
    stlg_timing i_stlg_timing (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lamp_r(lamp_r), .lamp_g(lamp_g), .lamp_b(lamp_b),
        .transfer_gate_pulse_a(tra), .transfer_gate_pulse_b(trb), .shift_clk(),
        .reset_gate_pulse(), .extra_pixel_pulse_a(), .extra_pixel_pulse_b(), .clamp(clamp),
        .sample_ref(sref), .sample_sig(ssig), .ref_internal(ref_int), .input_invert(inv),
        .adc_chan(chan), .coef_color(coef), .scanning(scan));
    stlg_sensor_model i_stlg_sensor_model (.clk(pclk), .clr(clr),
        .sig({ssig, sref, clamp, trb, tra, lamp_b, lamp_g, lamp_r}), .cnt(cnt));
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cc(input int i, input logic [15:0] e);
        chk({16'h0, cnt[i]}, {16'h0, e});
    endtask
    // one transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            num_errors++;
            summarize();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    // counts restart one edge after clr, then cover n whole edges
    task automatic meas(input int n);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (n) @(posedge pclk);
        @(posedge pclk);
    endtask
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        clr = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(stlg_pkg::OFF_CTRL, 32'h0000_0008);
        rd(stlg_pkg::OFF_PWM, 32'h0000_0800);
        rd(stlg_pkg::OFF_LAMP_BASE, 32'h0000_ffff);
        rd(stlg_pkg::OFF_SAMPLE, 32'h0000_0051);
        chk({29'h0, lamp_r, lamp_g, lamp_b}, 32'h0);
        apb(1'b0, 8'h38, 32'h0);
        chk({31'h0, err}, 32'h1);
        done("reset");
        wr(stlg_pkg::OFF_LINE_END, 32'hf);
        wr(stlg_pkg::OFF_OB_END, 32'h4);
        wr(stlg_pkg::OFF_PWM, 32'h400);
        foreach (pts[k]) wr(stlg_pkg::OFF_LAMP_BASE + 8'(4 * k), pts[k]);
        meas(1024);
        cc(0, 16'h0000);
        cc(1, 16'h0000);
        cc(3, 16'h0060);
        wr(stlg_pkg::OFF_CTRL, 32'h0000_000b);
        repeat (128) @(posedge pclk);
        meas(4096);
        cc(0, 16'h0300);
        cc(1, 16'h1000);
        cc(2, 16'h0000);
        cc(3, 16'h0180);
        cc(5, 16'h0420);
        cc(6, 16'h0200);
        done("all lamps");
        wr(stlg_pkg::OFF_CTRL, 32'h0000_0009);
        meas(4096);
        cc(0, 16'h0300);
        cc(1, 16'h0400);
        cc(2, 16'h0000);
        wr(stlg_pkg::OFF_CTRL, 32'h0000_000a);
        repeat (128) @(posedge pclk);
        meas(3072);
        cc(0, 16'h00c0);
        cc(1, 16'h0400);
        cc(2, 16'h0000);
        done("white and colour");
        wr(stlg_pkg::OFF_CTRL, 32'h0000_040b);
        meas(4096);
        cc(4, 16'h0180);
        wr(stlg_pkg::OFF_CTRL, 32'h0000_044b);
        meas(4096);
        cc(3, 16'h0100);
        wr(stlg_pkg::OFF_CTRL, 32'h0000_048b);
        meas(4096);
        cc(3, 16'h0100);
        wr(stlg_pkg::OFF_CTRL, 32'h0000_0013);
        repeat (4) @(posedge pclk);
        chk({30'h0, inv, ref_int}, 32'h3);
        meas(4096);
        cc(6, 16'h0000);
        cc(7, 16'h0200);
        done("sensor timing");
        wr(stlg_pkg::OFF_CTRL, 32'h0000_002e);
        for (int i = 0; i < 600 && scan !== 1'b1; i++) @(posedge pclk);
        chk({31'h0, scan}, 32'h1);
        if (scan !== 1'b1) summarize();
        repeat (2) @(posedge pclk);
        chk({28'h0, chan, coef}, 32'h0);
        repeat (130) @(posedge pclk);
        chk({28'h0, chan, coef}, 32'h5);
        done("scan");
        wr(stlg_pkg::OFF_CTRL, 32'h0000_020b);
        repeat (16) @(posedge pclk);
        apb(1'b0, stlg_pkg::OFF_STATUS, 32'h0);
        s = rdv;
        repeat (64) @(posedge pclk);
        rd(stlg_pkg::OFF_STATUS, s);
        meas(256);
        cc(0, 16'h0000);
        cc(3, 16'h0000);
        done("standby");
        summarize();
    end
endmodule
`default_nettype wire
